// [logic/ppigc_ctrl.sv]
// gang output control and pin interrupt logic with an AXI4-Lite slave
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - gang register accepts its first write only
// - select bits 7:1 map PB5..PB2, PC3..PC1
// - ganged pins output, follow port C bit0 controls
// - gang enable forces port C bit0 output
// - gang beats digital, analog beats gang
// - A3:0 and B3:0 interrupt and wake sources
// - per-pin select enables pin interrupt
// - per-port mode: edge or edge-and-level
// - per-pin polarity: falling/low or rising/high
// - edges found by per-cycle sampling
// - deasserted level must precede a counted edge
// - edge sets flag, request if enabled, ack clears
// - edge ignored while another enabled pin asserted
// - level mode: ack cannot clear asserted flag
// - polarity selects pull-up or pull-down
// - pin levels readable by software
// - stop2 keeps pin output latches
// - stop3 keeps all logic running
module ppigc_ctrl
  import ppigc_pkg::*;
(
  input wire logic aclk, // bus clock
  input wire logic aresetn, // synchronous reset, low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [7:0] gpio_dir, // own direction per gang pin
  input wire logic [7:0] gpio_data, // own data per gang pin
  input wire logic [7:0] gpio_drive, // own drive select per gang pin
  input wire logic [7:0] gpio_slew, // own slew enable per gang pin
  input wire logic [7:0] periph_en, // digital peripheral owns pin
  input wire logic [7:0] periph_oe, // peripheral output enable
  input wire logic [7:0] periph_out, // peripheral output value
  input wire logic [7:0] analog_en, // analog function owns pin
  input wire logic stop2_active, // partial power down in effect
  output logic [7:0] pin_oe, // gang pin output enable
  output logic [7:0] pin_out, // gang pin output value
  output logic [7:0] pin_drive, // gang pin high drive
  output logic [7:0] pin_slew, // gang pin slew limit
  input wire logic [7:0] irq_pin, // raw pins, 3:0 port A, 7:4 port B
  output logic [7:0] pull_up_en, // pull-up enable per pin
  output logic [7:0] pull_down_en, // pull-down enable per pin
  output logic [1:0] irq_req, // request per port to cpu
  output logic wake_req // wake from wait or stop3
);

  // ==================================================
  // address helpers
  // per-port register offset, base plus port stride
  function automatic logic [7:0] port_off(input logic [7:0] base, input int p);
    port_off = base + 8'(p) * OFF_PORT_STEP;
  endfunction

  // ==================================================
  // write channel of the bus slave
  logic aw_full;
  logic w_full;
  logic [7:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic do_write;
  logic wr_hit;
  logic bvalid;
  logic [1:0] bresp;

  // address and data taken in any order, held until both arrive
  assign s_axi_awready = ~aw_full;
  assign s_axi_wready = ~w_full;
  assign do_write = aw_full & w_full & ~bvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;

  // capture address and data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      waddr <= 8'h00;
      wdata <= 32'h0000_0000;
      wstrb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full)
      begin
        aw_full <= 1'b1;
        waddr <= s_axi_awaddr;
      end
      else if (do_write)
        aw_full <= 1'b0;
      if (s_axi_wvalid && !w_full)
      begin
        w_full <= 1'b1;
        wdata <= s_axi_wdata;
        wstrb <= s_axi_wstrb;
      end
      else if (do_write)
        w_full <= 1'b0;
    end
  end

  // response one cycle after the write is performed
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid <= 1'b0;
  end

  // ==================================================
  // gang register
  logic [7:0] gang;
  logic gang_locked;
  logic wr_gang;

  assign wr_gang = do_write && waddr == OFF_GANG && wstrb[0];

  // first write sticks, later ones are dropped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gang <= GANG_RST;
      gang_locked <= 1'b0;
    end
    else if (wr_gang && !gang_locked)
    begin
      gang <= wdata[7:0];
      gang_locked <= 1'b1;
    end
  end

  // ==================================================
  // gang pin steering, pin 0 is PC0, 1..3 PC1..PC3, 4..7 PB2..PB5
  ppigc_pin_t pin_q [NUM_GANG];
  ppigc_pin_t next_pin [NUM_GANG];
  logic [7:0] gang_on;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_GANG; gi++)
    begin : g_pin
      // enable bit itself selects PC0, other bits their own pins
      assign gang_on[gi] = gang[GANG_EN_BIT] & (gi == 0 ? 1'b1 : gang[gi]);
      // analog first, then gang, then peripheral, then gpio
      assign next_pin[gi].oe = analog_en[gi] ? 1'b0 : gang_on[gi] ? 1'b1 :
        periph_en[gi] ? periph_oe[gi] : gpio_dir[gi];
      assign next_pin[gi].out = gang_on[gi] ? gpio_data[0] :
        periph_en[gi] ? periph_out[gi] : gpio_data[gi];
      assign next_pin[gi].drive = gang_on[gi] ? gpio_drive[0] : gpio_drive[gi];
      assign next_pin[gi].slew = gang_on[gi] ? gpio_slew[0] : gpio_slew[gi];
      // latches hold their value through stop2
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          pin_q[gi] <= PIN_RST;
        else if (!stop2_active)
          pin_q[gi] <= next_pin[gi];
      end
      assign pin_oe[gi] = pin_q[gi].oe;
      assign pin_out[gi] = pin_q[gi].out;
      assign pin_drive[gi] = pin_q[gi].drive;
      assign pin_slew[gi] = pin_q[gi].slew;
    end
  endgenerate

  // ==================================================
  // pin input synchroniser
  logic [7:0] sync1;
  logic [7:0] sync2;

  // two stages before any detection logic
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end
    else
    begin
      sync1 <= irq_pin;
      sync2 <= sync1;
    end
  end

  // ==================================================
  // per-port interrupt detection
  ppigc_cfg_t cfg [NUM_PORTS];
  ppigc_sc_t sc [NUM_PORTS];
  logic [NUM_PORTS-1:0] wr_cfg;
  logic [NUM_PORTS-1:0] wr_sc;
  logic [NUM_PORTS-1:0] hit_cfg;
  logic [NUM_PORTS-1:0] hit_sc;
  logic [NUM_PORTS-1:0] ack;
  logic [NUM_PORTS-1:0] set_flag;
  logic [3:0] lvl [NUM_PORTS];
  logic [3:0] prev_lvl [NUM_PORTS];
  logic [3:0] edge_hit [NUM_PORTS];

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++)
    begin : g_port
      logic [3:0] s;
      logic [3:0] asserted_now;
      logic blocked;
      assign hit_cfg[gp] = waddr == port_off(OFF_CFG_A, gp);
      assign hit_sc[gp] = waddr == port_off(OFF_SC_A, gp);
      assign wr_cfg[gp] = do_write & hit_cfg[gp];
      assign wr_sc[gp] = do_write & hit_sc[gp] & wstrb[0];
      assign ack[gp] = wr_sc[gp] & wdata[SC_ACK_BIT];
      assign s = sync2[gp*PINS_PER_PORT +: PINS_PER_PORT];
      // asserted level after polarity
      assign lvl[gp] = ~(s ^ cfg[gp].polarity);
      assign asserted_now = lvl[gp] & cfg[gp].select;
      // rising of asserted level on an enabled pin
      assign edge_hit[gp] = asserted_now & ~prev_lvl[gp];
      // another enabled pin already asserted last cycle
      assign blocked = |(prev_lvl[gp] & cfg[gp].select);
      assign set_flag[gp] = sc[gp].mode ? (|asserted_now) :
        ((|edge_hit[gp]) & ~blocked);
      // previous level, reset as asserted so a deassert is seen first
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          prev_lvl[gp] <= PREV_LVL_RST;
        else
          prev_lvl[gp] <= lvl[gp];
      end
      // configuration register, byte lanes honoured
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          cfg[gp] <= CFG_RST;
        else if (wr_cfg[gp])
        begin
          if (wstrb[0])
          begin
            cfg[gp].select <= wdata[CFG_SEL_LSB +: 4];
            cfg[gp].polarity <= wdata[CFG_POL_LSB +: 4];
          end
          if (wstrb[1])
            cfg[gp].pull_en <= wdata[CFG_PULL_LSB +: 4];
        end
      end
      // status and control, a new event wins over ack
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          sc[gp] <= SC_RST;
        else
        begin
          sc[gp].flag <= set_flag[gp] | (sc[gp].flag & ~ack[gp]);
          if (wr_sc[gp])
          begin
            sc[gp].mode <= wdata[SC_MODE_BIT];
            sc[gp].ie <= wdata[SC_IE_BIT];
          end
        end
      end
      // pull direction from polarity, only where enabled
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          pull_up_en[gp*4 +: 4] <= 4'h0;
          pull_down_en[gp*4 +: 4] <= 4'h0;
        end
        else
        begin
          pull_up_en[gp*4 +: 4] <= cfg[gp].pull_en & ~cfg[gp].polarity;
          pull_down_en[gp*4 +: 4] <= cfg[gp].pull_en & cfg[gp].polarity;
        end
      end
      assign irq_req[gp] = sc[gp].flag & sc[gp].ie;
    end
  endgenerate

  // request doubles as wake source
  assign wake_req = |irq_req;
  assign wr_hit = waddr == OFF_GANG || (|hit_cfg) || (|hit_sc) || waddr == OFF_LEVEL;

  // ==================================================
  // read channel of the bus slave
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic [31:0] rd_mux;
  logic rd_hit;

  assign s_axi_arready = ~rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  // read data selection
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr == OFF_GANG)
      rd_mux = {24'h00_0000, gang};
    else if (s_axi_araddr == port_off(OFF_CFG_A, 0))
      rd_mux = {20'h0_0000, cfg[0]};
    else if (s_axi_araddr == port_off(OFF_SC_A, 0))
      rd_mux = {28'h000_0000, sc[0].flag, 1'b0, sc[0].ie, sc[0].mode};
    else if (s_axi_araddr == port_off(OFF_CFG_A, 1))
      rd_mux = {20'h0_0000, cfg[1]};
    else if (s_axi_araddr == port_off(OFF_SC_A, 1))
      rd_mux = {28'h000_0000, sc[1].flag, 1'b0, sc[1].ie, sc[1].mode};
    else if (s_axi_araddr == OFF_LEVEL)
      rd_mux = {24'h00_0000, sync2};
    else
      rd_hit = 1'b0;
  end

  // one read at a time, answer the cycle after acceptance
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid)
    begin
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid <= 1'b0;
  end

  // ==================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence gang_rewrite_s;
    gang_locked && wr_gang;
  endsequence

  gang_once_a: assert property (gang_rewrite_s |=> $stable(gang))
    else $error("gang register changed after first write");

  pc0_forced_a: assert property (
    gang[GANG_EN_BIT] && !analog_en[0] && !stop2_active |=> pin_oe[0])
    else $error("gang enable did not force pc0 output");

  gang_follow_a: assert property (
    gang_on[3] && !analog_en[3] && !stop2_active
    |=> pin_oe[3] && pin_out[3] == $past(gpio_data[0]) && pin_slew[3] == $past(gpio_slew[0]))
    else $error("ganged pin did not follow pc0 controls");

  analog_prio_a: assert property (
    !stop2_active && analog_en[1] |=> !pin_oe[1])
    else $error("analog function did not win over drive");

  stop_hold_a: assert property (
    stop2_active |=> $stable(pin_oe) && $stable(pin_out))
    else $error("pin latches moved during stop2");

  sequence edge_a0_s;
    sc[0].mode == 1'b0 && cfg[0].select[0] && !cfg[0].polarity[0]
      && !sync2[0] && (prev_lvl[0] & cfg[0].select) == 4'h0;
  endsequence

  edge_flag_a: assert property (edge_a0_s |=> sc[0].flag)
    else $error("falling edge did not set flag");

  block_edge_a: assert property (
    sc[0].mode == 1'b0 && !sc[0].flag && (|(prev_lvl[0] & cfg[0].select))
    |=> !sc[0].flag)
    else $error("edge latched while another pin asserted");

  level_hold_a: assert property (
    sc[1].mode && (|(lvl[1] & cfg[1].select)) && ack[1] |=> sc[1].flag)
    else $error("ack cleared flag while level asserted");

  ack_clear_a: assert property (
    ack[1] && !set_flag[1] |=> !sc[1].flag ##0 !irq_req[1])
    else $error("ack did not clear flag");

  sync_lag_a: assert property ($rose(irq_pin[4]) ##1 irq_pin[4] |=> sync2[4])
    else $error("pin not seen after two stages");

  pull_dir_a: assert property (
    cfg[1].pull_en[0] && cfg[1].polarity[0] |=> pull_down_en[4] && !pull_up_en[4])
    else $error("pull direction wrong");

  bresp_hold_a: assert property (bvalid && !s_axi_bready |=> bvalid)
    else $error("write response dropped early");

endmodule

// [logic/ppigc_pkg.sv]
// constants and carrier types for the port pin gang and interrupt block
package ppigc_pkg;
  // ==================================================
  // register byte offsets
  localparam logic [7:0] OFF_GANG = 8'h00;
  localparam logic [7:0] OFF_CFG_A = 8'h04;
  localparam logic [7:0] OFF_SC_A = 8'h08;
  localparam logic [7:0] OFF_PORT_STEP = 8'h08;
  localparam logic [7:0] OFF_LEVEL = 8'h14;
  // ==================================================
  // field positions
  localparam int GANG_EN_BIT = 0;
  localparam int SC_MODE_BIT = 0;
  localparam int SC_IE_BIT = 1;
  localparam int SC_ACK_BIT = 2;
  localparam int SC_FLAG_BIT = 3;
  localparam int CFG_SEL_LSB = 0;
  localparam int CFG_POL_LSB = 4;
  localparam int CFG_PULL_LSB = 8;
  // ==================================================
  // reset values and sizes
  localparam logic [7:0] GANG_RST = 8'h00;
  localparam logic [3:0] PREV_LVL_RST = 4'hf;
  localparam int NUM_GANG = 8;
  localparam int NUM_PORTS = 2;
  localparam int PINS_PER_PORT = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==================================================
  // per-port interrupt configuration
  typedef struct packed {
    logic [3:0] pull_en;
    logic [3:0] polarity;
    logic [3:0] select;
  } ppigc_cfg_t;
  // per-port status and control
  typedef struct packed {
    logic flag;
    logic ie;
    logic mode;
  } ppigc_sc_t;
  // drive state of one gang-capable pin
  typedef struct packed {
    logic oe;
    logic out;
    logic drive;
    logic slew;
  } ppigc_pin_t;
  localparam ppigc_cfg_t CFG_RST = 12'h000;
  localparam ppigc_sc_t SC_RST = 3'h0;
  localparam ppigc_pin_t PIN_RST = 4'h0;
endpackage

// [testbench/ppigc_pin_model.sv]
// pin-side model: external drivers and pull resolution on the interrupt pins
`timescale 1ns/1ps
module ppigc_pin_model (
  input wire logic aclk, // bus clock
  input wire logic [7:0] ext_en, // external driver active per pin
  input wire logic [7:0] ext_val, // external driver level per pin
  input wire logic [7:0] pull_up_en, // pull-up enable from the block
  input wire logic [7:0] pull_down_en, // pull-down enable from the block
  output logic [7:0] irq_pin // resolved pin level
);
  logic [7:0] last_drv = 8'h00;
  // ==================================================
  // last driven level, so a floating pin never keeps a stale value
  always @(posedge aclk)
  begin
    last_drv <= (ext_en & ext_val) | (~ext_en & last_drv);
  end
  // released pins follow their pull, unpulled ones drift to the inverse
  assign irq_pin = (ext_en & ext_val) | (~ext_en & pull_up_en) |
                   (~ext_en & ~pull_up_en & ~pull_down_en & ~last_drv);
endmodule

// [testbench/ppigc_ctrl_bench.sv]
// self-checking bench for the gang output and pin interrupt block
`timescale 1ns/1ps
module ppigc_ctrl_bench
  import ppigc_pkg::*;
;
  localparam logic [7:0] CFG_B = OFF_CFG_A + OFF_PORT_STEP;
  localparam logic [7:0] SC_B = OFF_SC_A + OFF_PORT_STEP;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, stop2, wake_req;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, gdir, gdata, gdrive, gslew, pen, poe, pout, aen;
  logic [7:0] pin_oe, pin_out, pin_drive, pin_slew, irq_pin, pu, pd, ext_en, ext_val;
  logic [31:0] wdata, rdata, rd_val;
  logic [1:0] bresp, rresp, resp, irq_req;
  int error_cnt, samples_checked;
  // ==================================================
  // clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ==================================================
  // design and pin model
  ppigc_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .gpio_dir(gdir), .gpio_data(gdata), .gpio_drive(gdrive),
    .gpio_slew(gslew), .periph_en(pen), .periph_oe(poe), .periph_out(pout),
    .analog_en(aen), .stop2_active(stop2), .pin_oe(pin_oe), .pin_out(pin_out),
    .pin_drive(pin_drive), .pin_slew(pin_slew), .irq_pin(irq_pin),
    .pull_up_en(pu), .pull_down_en(pd), .irq_req(irq_req), .wake_req(wake_req));
  ppigc_pin_model pins (.aclk(aclk), .ext_en(ext_en), .ext_val(ext_val),
    .pull_up_en(pu), .pull_down_en(pd), .irq_pin(irq_pin));
  // ==================================================
  // verdict, compare, bus tasks
  task automatic close_out();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (n == 40)
    begin
      error_cnt++;
      close_out();
    end
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd_val = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n == 40)
    begin
      error_cnt++;
      close_out();
    end
  endtask
  // pins change after an edge; flag shows 3 edges later, sampled at the 4th
  task automatic drive_pins(input logic [7:0] en, input logic [7:0] val);
    @(posedge aclk);
    ext_en <= en;
    ext_val <= val;
    repeat (4) @(posedge aclk);
  endtask
  // ==================================================
  // main sequence
  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, stop2} = 6'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    {gdir, pen, poe, pout, aen} = 40'h0;
    gdata = 8'h01;
    gdrive = 8'h01;
    gslew = 8'h01;
    ext_en = 8'hff;
    ext_val = 8'h0f;
    error_cnt = 0;
    samples_checked = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // reset value and unmapped places
    rd(OFF_GANG);
    chk(rd_val, 32'(GANG_RST));
    rd(8'h20);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(8'h20, 32'h1);
    chk(32'(resp), 32'(RESP_SLVERR));
    // gang on PC0, PC1, PC3 then a second write that must be ignored
    wr(OFF_GANG, 32'h0000_000b);
    wr(OFF_GANG, 32'h0000_00ff);
    chk(32'(resp), 32'(RESP_OKAY));
    rd(OFF_GANG);
    chk(rd_val, 32'h0000_000b);
    repeat (2) @(posedge aclk);
    chk(32'(pin_oe), 32'h0b);
    chk(32'(pin_out & pin_oe), 32'h0b);
    chk(32'({pin_drive & pin_oe, pin_slew & pin_oe}), 32'h0b0b);
    // analog beats gang, gang beats peripheral
    @(posedge aclk);
    pen <= 8'h08;
    aen <= 8'h02;
    repeat (2) @(posedge aclk);
    chk(32'(pin_oe), 32'h09);
    // stop2 holds output latches
    @(posedge aclk);
    stop2 <= 1'b1;
    gdata <= 8'h00;
    repeat (2) @(posedge aclk);
    chk(32'(pin_out & pin_oe), 32'h09);
    @(posedge aclk);
    stop2 <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(32'(pin_out & pin_oe), 32'h00);
    // port A: edge mode, falling, pins 1:0 selected with pull-ups
    wr(OFF_SC_A, 32'h0);
    wr(OFF_CFG_A, 32'h0000_0303);
    drive_pins(8'hfc, 8'h0f);
    chk(32'({pd, pu}), 32'h0003);
    wr(OFF_SC_A, 32'h4);
    wr(OFF_SC_A, 32'h2);
    rd(OFF_LEVEL);
    chk(rd_val, 32'h0000_000f);
    rd(OFF_SC_A);
    chk(rd_val, 32'h2);
    drive_pins(8'hfc, 8'h0b);
    chk(32'({wake_req, irq_req}), 32'h0);
    drive_pins(8'hfd, 8'h0e);
    chk(32'({wake_req, irq_req}), 32'h5);
    rd(OFF_SC_A);
    chk(rd_val, 32'ha);
    wr(OFF_SC_A, 32'h6);
    rd(OFF_SC_A);
    chk(rd_val, 32'h2);
    drive_pins(8'hff, 8'h0c);
    chk(32'(irq_req), 32'h0);
    // mask the asserted pin so the other one can raise a request
    drive_pins(8'hfd, 8'h0e);
    wr(OFF_CFG_A, 32'h0000_0302);
    drive_pins(8'hff, 8'h0c);
    chk(32'(irq_req), 32'h1);
    wr(OFF_SC_A, 32'h6);
    wr(OFF_CFG_A, 32'h0000_0303);
    drive_pins(8'hfc, 8'h0f);
    chk(32'(irq_req), 32'h0);
    // port B: edge and level mode, rising, pin 0 with pull-down
    wr(SC_B, 32'h0);
    wr(CFG_B, 32'h0000_0111);
    drive_pins(8'hec, 8'h0f);
    chk(32'({pd, pu}), 32'h1003);
    wr(SC_B, 32'h4);
    wr(SC_B, 32'h3);
    drive_pins(8'hfc, 8'h1f);
    chk(32'({wake_req, irq_req}), 32'h6);
    wr(SC_B, 32'h7);
    rd(SC_B);
    chk(rd_val, 32'hb);
    drive_pins(8'hec, 8'h0f);
    wr(SC_B, 32'h7);
    rd(SC_B);
    chk(rd_val, 32'h3);
    chk(32'(irq_req), 32'h0);
    close_out();
  end
endmodule
